// file: core/ram_pkg.sv
// Contract
// - weekly hour bit5 is pm flag or tens
// - daily hour bit5 is pm flag or tens
// - 12-hour midnight code 12, noon 32
// - day enable bit n matches weekday code n
// - all day enables zero means no match
// - alarm fires only on exact time equality
// - unused bit 7 reads 0 while halted
// - halt flag sets on power-on or stop
package ram_pkg;
  localparam logic [3:0] RAM_OFS_WMIN = 4'h8;
  localparam logic [3:0] RAM_OFS_WHOUR = 4'h9;
  localparam logic [3:0] RAM_OFS_WDAY = 4'hA;
  localparam logic [3:0] RAM_OFS_DMIN = 4'hB;
  localparam logic [3:0] RAM_OFS_DHOUR = 4'hC;
  localparam logic [7:0] RAM_MIN_MASK = 8'h7F;
  localparam logic [7:0] RAM_HOUR_MASK = 8'h3F;
  localparam logic [7:0] RAM_DAY_MASK = 8'h7F;
  localparam int RAM_PM_BIT = 5;
  localparam logic [7:0] RAM_RST_VAL = 8'h00;
  localparam logic RAM_HALT_RST = 1'b1;
  localparam logic RAM_PREV_RST = 1'b1;

  // time that the counters present for comparison
  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
    logic [2:0] weekday;
  } ram_time_s;

  // register write strobe with its address and data
  typedef struct packed {
    logic we;
    logic [3:0] addr;
    logic [7:0] data;
  } ram_wr_s;
endpackage : ram_pkg

// file: core/ram_cmp.sv
`timescale 1ns/1ps
`default_nettype none
module ram_cmp (
  // alarm settings
  input wire logic [6:0] alm_min,
  input wire logic [5:0] alm_hour,
  input wire logic [6:0] day_en,
  input wire logic use_day,
  // running time
  input wire ram_pkg::ram_time_s now,
  // result
  output logic hit
);
  import ram_pkg::*;
  wire time_eq;
  wire day_ok;
  // hour compared whole, so bit5 means pm or tens alike
  assign time_eq = (alm_min == now.minute) && (alm_hour == now.hour);
  // code 7 selects no enable bit, so it never passes the day check
  assign day_ok = (now.weekday != 3'h7) && day_en[now.weekday];
  assign hit = time_eq && (!use_day || day_ok);
endmodule : ram_cmp
`default_nettype wire

// file: core/ram_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ram_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port from the serial host interface
  input wire ram_pkg::ram_wr_s wr,
  input wire logic [3:0] rd_addr,
  output logic [7:0] rd_data,
  // oscillator status
  input wire logic osc_stop,
  input wire logic osc_halt_clr,
  output logic osc_halt_flag,
  // running time and matches
  input wire ram_pkg::ram_time_s now,
  output logic weekly_match,
  output logic daily_match
);
  import ram_pkg::*;

  // shared address compare for the write and the read decode
  function automatic logic addr_is(input logic [3:0] a,
                                   input logic [3:0] ofs);
    return a == ofs;
  endfunction : addr_is

  logic [6:0] wmin_q;
  logic [5:0] whour_q;
  logic [6:0] wday_q;
  logic [6:0] dmin_q;
  logic [5:0] dhour_q;
  logic halt_q;
  logic [7:0] rd_q;
  logic wm_q;
  logic dm_q;
  logic wm_prev_q;
  logic dm_prev_q;

  wire w_hit;
  wire d_hit;
  wire [7:0] rd_d;
  wire we_wmin, we_whour, we_wday, we_dmin, we_dhour;
  wire rs_wmin, rs_whour, rs_wday, rs_dmin, rs_dhour, rs_none;

  // address decode of the write strobe
  assign we_wmin = wr.we && addr_is(wr.addr, RAM_OFS_WMIN);
  assign we_whour = wr.we && addr_is(wr.addr, RAM_OFS_WHOUR);
  assign we_wday = wr.we && addr_is(wr.addr, RAM_OFS_WDAY);
  assign we_dmin = wr.we && addr_is(wr.addr, RAM_OFS_DMIN);
  assign we_dhour = wr.we && addr_is(wr.addr, RAM_OFS_DHOUR);

  // read select decode, the same compare as the write side
  assign rs_wmin = addr_is(rd_addr, RAM_OFS_WMIN);
  assign rs_whour = addr_is(rd_addr, RAM_OFS_WHOUR);
  assign rs_wday = addr_is(rd_addr, RAM_OFS_WDAY);
  assign rs_dmin = addr_is(rd_addr, RAM_OFS_DMIN);
  assign rs_dhour = addr_is(rd_addr, RAM_OFS_DHOUR);
  assign rs_none = !(rs_wmin || rs_whour || rs_wday || rs_dmin || rs_dhour);

  // storage; upper bits are never kept, so they cannot read back
  always_ff @(posedge mclk) begin
    if (rst) begin
      wmin_q <= RAM_RST_VAL[6:0];
      whour_q <= RAM_RST_VAL[5:0];
      wday_q <= RAM_RST_VAL[6:0];
      dmin_q <= RAM_RST_VAL[6:0];
      dhour_q <= RAM_RST_VAL[5:0];
    end else begin
      if (we_wmin) wmin_q <= wr.data[6:0];
      if (we_whour) whour_q <= wr.data[5:0];
      if (we_wday) wday_q <= wr.data[6:0];
      if (we_dmin) dmin_q <= wr.data[6:0];
      if (we_dhour) dhour_q <= wr.data[5:0];
    end
  end

  // halt flag: power-on reset or a stop sets it; a stop beats a clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      halt_q <= RAM_HALT_RST;
    end else if (osc_stop) begin
      halt_q <= 1'b1;
    end else if (osc_halt_clr) begin
      halt_q <= 1'b0;
    end
  end

  // read mux; bit 7 is always zero even while data is unreliable
  assign rd_d = rs_wmin ? {1'b0, wmin_q} :
                rs_whour ? {2'b00, whour_q} :
                rs_wday ? {1'b0, wday_q} :
                rs_dmin ? {1'b0, dmin_q} :
                rs_dhour ? {2'b00, dhour_q} :
                8'h00;

  ram_cmp u_wcmp (
    .alm_min(wmin_q),
    .alm_hour(whour_q),
    .day_en(wday_q),
    .use_day(1'b1),
    .now(now),
    .hit(w_hit)
  );

  ram_cmp u_dcmp (
    .alm_min(dmin_q),
    .alm_hour(dhour_q),
    .day_en(7'h00),
    .use_day(1'b0),
    .now(now),
    .hit(d_hit)
  );

  // read data register, one edge behind the address it answers
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_q <= RAM_RST_VAL;
    end else begin
      rd_q <= rd_d;
    end
  end

  // one-cycle pulses on entering the matching minute; history starts as
  // matched so reset values equal to the running time give no false pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      wm_q <= 1'b0;
      dm_q <= 1'b0;
      wm_prev_q <= RAM_PREV_RST;
      dm_prev_q <= RAM_PREV_RST;
    end else begin
      wm_prev_q <= w_hit;
      dm_prev_q <= d_hit;
      wm_q <= w_hit && !wm_prev_q;
      dm_q <= d_hit && !dm_prev_q;
    end
  end

  assign rd_data = rd_q;
  assign osc_halt_flag = halt_q;
  assign weekly_match = wm_q;
  assign daily_match = dm_q;

  // weekly pulse only when all fields equal, one cycle after the cause
  weekly_cause_a: assert property (@(posedge mclk) disable iff (rst)
    weekly_match |-> $past(w_hit) && !$past(wm_prev_q))
    else $error("weekly match without time and day equality");
  weekly_fire_a: assert property (@(posedge mclk) disable iff (rst)
    (w_hit && !wm_prev_q) |=> weekly_match)
    else $error("weekly match missed");
  weekly_time_a: assert property (@(posedge mclk) disable iff (rst)
    weekly_match |-> $past(wmin_q) == $past(now.minute) &&
      $past(whour_q) == $past(now.hour))
    else $error("weekly match on wrong time");
  weekly_day_a: assert property (@(posedge mclk) disable iff (rst)
    weekly_match |-> $past((wday_q >> now.weekday) & 7'h01) != 7'h00)
    else $error("weekly match on a disabled day");
  weekly_zero_a: assert property (@(posedge mclk) disable iff (rst)
    (wday_q == 7'h00) |=> !weekly_match)
    else $error("weekly match with empty day mask");
  weekly_once_a: assert property (@(posedge mclk) disable iff (rst)
    weekly_match |=> !weekly_match)
    else $error("weekly match longer than one cycle");
  day_map_a: assert property (@(posedge mclk) disable iff (rst)
    !(w_hit && now.weekday == 3'h7))
    else $error("weekday code 7 matched");

  // daily pulse on minute and hour only, never straight out of reset
  daily_fire_a: assert property (@(posedge mclk) disable iff (rst)
    (d_hit && !dm_prev_q) |=> daily_match)
    else $error("daily match missed");
  daily_time_a: assert property (@(posedge mclk) disable iff (rst)
    daily_match |-> $past(dmin_q) == $past(now.minute))
    else $error("daily match on wrong minute");
  daily_hour_a: assert property (@(posedge mclk) disable iff (rst)
    daily_match |-> $past(dhour_q) == $past(now.hour))
    else $error("daily match on wrong hour");
  daily_once_a: assert property (@(posedge mclk) disable iff (rst)
    daily_match |=> !daily_match)
    else $error("daily match longer than one cycle");
  reset_quiet_a: assert property (@(posedge mclk) disable iff (rst)
    $past(rst) |=> !weekly_match && !daily_match)
    else $error("match pulse straight out of reset");

  // stored fields and what reads back
  top_bit_a: assert property (@(posedge mclk) disable iff (rst)
    !rd_data[7])
    else $error("bit 7 read as one");
  hour_top_a: assert property (@(posedge mclk) disable iff (rst)
    ($past(rd_addr) == RAM_OFS_DHOUR) |-> rd_data[7:6] == 2'b00)
    else $error("hour register upper bits nonzero");
  unmapped_rd_a: assert property (@(posedge mclk) disable iff (rst)
    $past(rs_none) |-> rd_data == 8'h00)
    else $error("unmapped address read nonzero");
  whour_keep_a: assert property (@(posedge mclk) disable iff (rst)
    we_whour |=> whour_q[RAM_PM_BIT] == $past(wr.data[RAM_PM_BIT]))
    else $error("weekly hour bit5 not stored");
  dhour_keep_a: assert property (@(posedge mclk) disable iff (rst)
    we_dhour |=> dhour_q[RAM_PM_BIT] == $past(wr.data[RAM_PM_BIT]))
    else $error("daily hour bit5 not stored");
  whour_read_a: assert property (@(posedge mclk) disable iff (rst)
    (!$past(rst) && $past(rd_addr) == RAM_OFS_WHOUR) |->
      rd_data[RAM_PM_BIT] == $past(whour_q[RAM_PM_BIT]))
    else $error("weekly hour bit5 not read back");
  dhour_read_a: assert property (@(posedge mclk) disable iff (rst)
    (!$past(rst) && $past(rd_addr) == RAM_OFS_DHOUR) |->
      rd_data[RAM_PM_BIT] == $past(dhour_q[RAM_PM_BIT]))
    else $error("daily hour bit5 not read back");
  wmin_keep_a: assert property (@(posedge mclk) disable iff (rst)
    we_wmin |=> wmin_q == $past(wr.data[6:0]))
    else $error("weekly minute not stored");
  dmin_keep_a: assert property (@(posedge mclk) disable iff (rst)
    we_dmin |=> dmin_q == $past(wr.data[6:0]))
    else $error("daily minute not stored");
  wday_keep_a: assert property (@(posedge mclk) disable iff (rst)
    we_wday |=> wday_q == $past(wr.data[6:0]))
    else $error("day mask not stored");

  // halt flag set, clear and hold
  halt_set_a: assert property (@(posedge mclk) disable iff (rst)
    osc_stop |=> osc_halt_flag)
    else $error("halt flag not set by stop");
  halt_clr_a: assert property (@(posedge mclk) disable iff (rst)
    (osc_halt_clr && !osc_stop) |=> !osc_halt_flag)
    else $error("halt flag not cleared");
  halt_keep_a: assert property (@(posedge mclk) disable iff (rst)
    (!osc_stop && !osc_halt_clr) |=> $stable(osc_halt_flag))
    else $error("halt flag changed on its own");
endmodule : ram_regs
`default_nettype wire

// file: verification/ram_host.sv
`timescale 1ns/1ps
`default_nettype none
module ram_host (
  // clock
  input wire logic mclk,
  // register port
  output ram_pkg::ram_wr_s wr
);
  import ram_pkg::*;
  initial wr = '0;
  // one byte, then release with inverted lines so no stale value lingers
  // host writes any byte it is given, weekday naming is its own
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk) wr <= '{1'b1, a, d};
    @(posedge mclk) wr <= '{1'b0, ~a, ~d};
  endtask : put
endmodule : ram_host
`default_nettype wire

// file: verification/ram_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ram_regs_bench;
  import ram_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] rd_addr = 4'h0;
  logic osc_stop = 1'b0;
  logic osc_halt_clr = 1'b0;
  ram_time_s now = '0;
  ram_wr_s wr;
  logic [7:0] rd_data;
  logic osc_halt_flag, weekly_match, daily_match;
  int failures = 0;
  int compares = 0;
  // 200 MHz
  always #2.5 mclk = ~mclk;
  ram_host i_ram_host (.mclk(mclk), .wr(wr));
  ram_regs i_ram_regs (.mclk(mclk), .rst(rst), .wr(wr), .rd_addr(rd_addr),
    .rd_data(rd_data), .osc_stop(osc_stop), .osc_halt_clr(osc_halt_clr),
    .osc_halt_flag(osc_halt_flag), .now(now),
    .weekly_match(weekly_match), .daily_match(daily_match));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // read answer lands one edge after the address is sampled
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk) rd_addr <= a;
    repeat (2) @(posedge mclk);
    #1 chk(rd_data, exp);
  endtask : rd
  // matches are one-cycle pulses one edge after the time arrives
  task automatic at(input ram_time_s t, input logic w, input logic d);
    @(posedge mclk) now <= t;
    @(posedge mclk) #1;
    chk(weekly_match, w);
    chk(daily_match, d);
  endtask : at
  // leaving reset with alarms equal to the running time must not pulse
  task automatic t_boot();
    repeat (3) begin
      @(posedge mclk) #1;
      chk(daily_match, 8'h00);
      chk(weekly_match, 8'h00);
      chk(rd_data, 8'h00);
    end
  endtask : t_boot
  // unused high bits drop writes, even while halted; unmapped reads 0
  task automatic t_regs();
    logic [7:0] m [5] = '{RAM_MIN_MASK, RAM_HOUR_MASK, RAM_DAY_MASK,
                          RAM_MIN_MASK, RAM_HOUR_MASK};
    for (int i = 0; i < 5; i++) begin
      i_ram_host.put(4'(RAM_OFS_WMIN + i), 8'hFF);
      rd(4'(RAM_OFS_WMIN + i), m[i]);
    end
    i_ram_host.put(4'hF, 8'hA5);
    rd(4'hF, 8'h00);
  endtask : t_regs
  // noon code 32 fires once; midnight code 12 is a different time
  task automatic t_daily();
    i_ram_host.put(RAM_OFS_DMIN, 8'h30);
    i_ram_host.put(RAM_OFS_DHOUR, 8'h32);
    at('{7'h30, 6'h32, 3'd0}, 1'b0, 1'b1);
    at('{7'h30, 6'h32, 3'd0}, 1'b0, 1'b0);
    at('{7'h30, 6'h12, 3'd0}, 1'b0, 1'b0);
    i_ram_host.put(RAM_OFS_DHOUR, 8'h12);
    at('{7'h31, 6'h12, 3'd0}, 1'b0, 1'b0);
    at('{7'h30, 6'h12, 3'd0}, 1'b0, 1'b1);
  endtask : t_daily
  // each day bit alone against every weekday code, then an empty mask
  task automatic t_week();
    i_ram_host.put(RAM_OFS_WMIN, 8'h15);
    i_ram_host.put(RAM_OFS_WHOUR, 8'h23);
    for (int k = 0; k < 8; k++) begin
      i_ram_host.put(RAM_OFS_WDAY, k < 7 ? 8'(1 << k) : 8'h00);
      for (int d = 0; d < 8; d++) begin
        at('{7'h00, 6'h23, 3'(d)}, 1'b0, 1'b0);
        at('{7'h15, 6'h23, 3'(d)}, d == k && k < 7, 1'b0);
      end
    end
  endtask : t_week
  // stop wins over a simultaneous clear
  task automatic t_halt();
    chk(osc_halt_flag, 8'h01);
    @(posedge mclk) osc_halt_clr <= 1'b1;
    @(posedge mclk) osc_halt_clr <= 1'b0;
    #1 chk(osc_halt_flag, 8'h00);
    @(posedge mclk) {osc_stop, osc_halt_clr} <= 2'b11;
    @(posedge mclk) {osc_stop, osc_halt_clr} <= 2'b00;
    #1 chk(osc_halt_flag, 8'h01);
  endtask : t_halt
  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_boot();
    t_regs();
    t_daily();
    t_week();
    t_halt();
    end_of_test();
  end
  // watchdog against a hang
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule : ram_regs_bench
`default_nettype wire
